// ===== src/tks_top.sv
// Touch key scan counters: slot timer, key and reference counters.
// Assumes synchronous oscillator tick pulses and a Wishbone master.
// Functional notes
// - Two key channels, own oscillator each
// - Unit period from 5-bit divider, 32 clocks
// - Slot counter runs preload to overflow
// - Slot overflow sets its flag and irq
// - Software setting slot flag leaves irq
// - Slot overflow stops oscillators and counters
// - Start low clears counters and divider
// - Start low keeps slot counter contents
// - Start rising launches oscillators and counters
// - Key counter overflow sets sticky flag
// - Reference counter overflow sets sticky flag
// - Reference counter clock is system/1,2,4,8
// - Control bit 7 reads zero
// - Counters hold final counts after overflow
// - Oscillator frequency select, reset code 11
module tks_top
  import tks_pkg::*;
(
  input  wire logic        clk_i,       // System clock, 25 MHz
  input  wire logic        rst_i,       // Synchronous reset
  input  wire logic        ce_i,        // Clock enable
  input  wire logic        wb_cyc_i,    // Wishbone cycle
  input  wire logic        wb_stb_i,    // Wishbone strobe
  input  wire logic        wb_we_i,     // Wishbone write
  input  wire logic [7:0]  wb_adr_i,    // Byte address
  input  wire logic [3:0]  wb_sel_i,    // Byte lanes
  input  wire logic [31:0] wb_dat_i,    // Write data
  output logic      [31:0] wb_dat_o,    // Read data
  output logic             wb_ack_o,    // Acknowledge
  input  wire logic [1:0]  key_tick_i,  // Key oscillator pulses
  input  wire logic        slot_tick_i, // Slot clock pulses
  output tks_osc_s         osc_o,       // Oscillator controls
  output logic             irq_o        // Touch irq request flag
);

  //////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [7:0]  preload;
    logic        start;
    logic        slot_ovf;
    logic        key_ovf;
    logic        ref_ovf;
    logic        rsv;
    logic [1:0]  ref_sel;
    logic [1:0]  freq;
    logic [9:0]  cap;
    logic [7:0]  mc0;
    logic [7:0]  mc1;
    logic        irq;
    logic        run;
    logic [4:0]  div;
    logic [7:0]  slot;
    logic [2:0]  pre;
  } tks_state_s;

  tks_state_s st_ff;
  tks_state_s nxt_st;

  logic        req;
  logic        wr;
  logic        ctl0_wr;
  logic        start_rise;
  logic        start_nxt;
  logic        cnt_en;
  logic        unit_end;
  logic        slot_evt;
  logic        ref_inc;
  logic        key_inc;
  logic        cnt_clr;
  logic [7:0]  wdat;
  logic [15:0] ref_cnt;
  logic [15:0] key_cnt;
  logic        ref_wrap;
  logic        key_wrap;

  //////////////////////////////////////////////////////////////////////
  // Bus decode

  assign req     = wb_cyc_i && wb_stb_i && !st_ff.ack;
  assign wr      = req && wb_we_i && wb_sel_i[0];
  assign wdat    = wb_dat_i[7:0];
  assign ctl0_wr = wr && (wb_adr_i == OFS_CTL0);

  // Start edge is judged against the stored bit
  assign start_rise = ctl0_wr && wdat[B_START] && !st_ff.start;
  // Start value after this cycle's write, kept off the next-state loop
  assign start_nxt = ctl0_wr ? wdat[B_START] : st_ff.start;
  // Clearing start freezes counting in the same cycle
  assign cnt_en   = st_ff.run && start_nxt;
  assign unit_end = cnt_en && slot_tick_i && (st_ff.div == DIV_LAST);
  assign slot_evt = unit_end && (st_ff.slot == SLOT_LAST);
  assign cnt_clr  = !start_nxt;
  assign ref_inc = cnt_en && ce_i &&
                   ((st_ff.pre & tks_pre_mask(st_ff.ref_sel)) ==
                    tks_pre_mask(st_ff.ref_sel));
  assign key_inc = cnt_en && ce_i &&
                   key_tick_i[st_ff.mc1[B_KEY_SEL]];

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = req;
    if (req && !wb_we_i) begin
      nxt_st.dat = '0;
      case (wb_adr_i)
        OFS_PRELOAD: nxt_st.dat[7:0] = st_ff.preload;
        OFS_CTL0: begin
          nxt_st.dat[7:0] = {1'b0, st_ff.slot_ovf, st_ff.start,
                             st_ff.key_ovf, st_ff.ref_ovf, st_ff.rsv,
                             st_ff.ref_sel};
        end
        OFS_CTL1:   nxt_st.dat[1:0] = st_ff.freq;
        OFS_REF_LO: nxt_st.dat[7:0] = ref_cnt[7:0];
        OFS_REF_HI: nxt_st.dat[7:0] = ref_cnt[15:8];
        OFS_KEY_LO: nxt_st.dat[7:0] = key_cnt[7:0];
        OFS_KEY_HI: nxt_st.dat[7:0] = key_cnt[15:8];
        OFS_CAP_LO: nxt_st.dat[7:0] = st_ff.cap[7:0];
        OFS_CAP_HI: nxt_st.dat[1:0] = st_ff.cap[9:8];
        OFS_MC0:    nxt_st.dat[7:0] = st_ff.mc0;
        OFS_MC1:    nxt_st.dat[7:0] = st_ff.mc1;
        OFS_IRQ:    nxt_st.dat[0]   = st_ff.irq;
        default:    nxt_st.dat      = '0;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        OFS_PRELOAD: nxt_st.preload = wdat;
        OFS_CTL0: begin
          // Software may write ones here; a write here never raises irq
          nxt_st.slot_ovf = wdat[B_SLOT_OVF];
          nxt_st.start    = wdat[B_START];
          nxt_st.key_ovf  = wdat[B_KEY_OVF];
          nxt_st.ref_ovf  = wdat[B_REF_OVF];
          nxt_st.rsv      = wdat[B_RSV];
          nxt_st.ref_sel  = wdat[1:0];
        end
        OFS_CTL1:   nxt_st.freq      = wdat[1:0];
        OFS_CAP_LO: nxt_st.cap[7:0]  = wdat;
        OFS_CAP_HI: nxt_st.cap[9:8]  = wdat[1:0];
        OFS_MC0:    nxt_st.mc0       = wdat;
        OFS_MC1:    nxt_st.mc1       = wdat;
        OFS_IRQ:    nxt_st.irq       = wdat[0];
        default:    nxt_st.irq       = st_ff.irq;
      endcase
    end

    // Scan engine
    if (start_rise) begin
      nxt_st.run  = 1'b1;
      nxt_st.slot = st_ff.preload;
    end else if (slot_evt || !nxt_st.start) begin
      nxt_st.run  = 1'b0;
    end
    if (!nxt_st.start) begin
      nxt_st.div = '0;
      nxt_st.pre = PRE_ZERO;
    end else if (cnt_en) begin
      nxt_st.pre = st_ff.pre + PRE_ONE;
      if (slot_tick_i) begin
        nxt_st.div = st_ff.div + DIV_ONE;
      end
      if (unit_end) begin
        nxt_st.slot = st_ff.slot + SLOT_ONE;
      end
    end

    // Hardware set wins over a same-cycle software clear
    if (slot_evt) begin
      nxt_st.slot_ovf = 1'b1;
      nxt_st.irq      = 1'b1;
    end
    if (key_wrap) begin
      nxt_st.key_ovf = 1'b1;
    end
    if (ref_wrap) begin
      nxt_st.ref_ovf = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff         <= '0;
      st_ff.preload <= BYTE_RST;
      st_ff.freq    <= FREQ_RST;
      st_ff.cap     <= CAP_RST;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Counters

  tks_cnt16 u_key_cnt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .clr_i (cnt_clr),
    .inc_i (key_inc),
    .cnt_o (key_cnt),
    .ovf_o (key_wrap)
  );

  tks_cnt16 u_ref_cnt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .clr_i (cnt_clr),
    .inc_i (ref_inc),
    .cnt_o (ref_cnt),
    .ovf_o (ref_wrap)
  );

  //////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_o      = st_ff.ack;
  assign wb_dat_o      = st_ff.dat;
  assign irq_o         = st_ff.irq;
  assign osc_o.en      = st_ff.run;
  assign osc_o.freq    = st_ff.freq;
  assign osc_o.key_sel = st_ff.mc1[B_KEY_SEL];
  assign osc_o.cap     = st_ff.cap;

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_slot_ovf_flags: assert property (
    (ce_i && slot_evt) |=> (st_ff.slot_ovf && st_ff.irq))
    else $error("slot overflow did not set flag and irq");

  a_stop_on_ovf: assert property (
    (ce_i && slot_evt) |=> (!st_ff.run && !osc_o.en))
    else $error("scan kept running after slot overflow");

  a_hold_counts: assert property (
    (ce_i && !st_ff.run && st_ff.start && !ctl0_wr)
      |=> ($stable(key_cnt) && $stable(ref_cnt)))
    else $error("counts changed after the window ended");

  a_clear_stopped: assert property (
    !st_ff.start |-> (key_cnt == '0 && ref_cnt == '0 && st_ff.div == '0))
    else $error("counters not cleared while start is low");

  a_slot_kept: assert property (
    $fell(st_ff.start) |-> (st_ff.slot == $past(st_ff.slot)))
    else $error("slot counter changed on start clear");

  a_sw_no_irq: assert property (
    (ce_i && ctl0_wr && wdat[B_SLOT_OVF] && !slot_evt && !st_ff.irq)
      |=> !st_ff.irq)
    else $error("software write raised the irq flag");

  a_start_launch: assert property (
    (ce_i && start_rise)
      |=> (st_ff.run && st_ff.slot == $past(st_ff.preload)))
    else $error("start did not launch the scan");

  a_key_sticky: assert property (
    (ce_i && key_wrap) |=> (st_ff.key_ovf && key_cnt == '0))
    else $error("key overflow flag not set on wrap");

  a_ref_sticky: assert property (
    (ce_i && ref_wrap) |=> st_ff.ref_ovf)
    else $error("reference overflow flag not set");

  a_ref_divided: assert property (
    (ref_inc && st_ff.ref_sel != 2'h0) |=> !ref_inc)
    else $error("reference counter ran at full rate");

  a_bit7_zero: assert property (
    (ce_i && req && !wb_we_i && wb_adr_i == OFS_CTL0) |=> !wb_dat_o[7])
    else $error("control bit 7 read as one");

  a_ack_single: assert property (
    (ce_i && wb_ack_o) |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  //////////////////////////////////////////////////////////////////////
  // Counter and flag checks

  a_div_step: assert property (
    (ce_i && cnt_en && slot_tick_i)
      |=> (st_ff.div == $past(st_ff.div) + DIV_ONE))
    else $error("unit divider missed a slot tick");

  a_slot_step: assert property (
    (ce_i && unit_end) |=> (st_ff.slot == $past(st_ff.slot) + SLOT_ONE))
    else $error("slot counter missed a unit end");

  a_slot_held: assert property (
    (ce_i && !st_ff.run && !start_rise) |=> $stable(st_ff.slot))
    else $error("slot counter moved while stopped");

  a_stop_clear: assert property (
    (ce_i && ctl0_wr && !wdat[B_START]) |=> (!st_ff.run && !osc_o.en))
    else $error("scan kept running after start was cleared");

  a_pre_clear: assert property (
    !st_ff.start |-> (st_ff.pre == PRE_ZERO))
    else $error("reference prescaler not cleared while start is low");

  a_run_start: assert property (
    st_ff.run |-> st_ff.start)
    else $error("scan running without start");

  a_ref_full: assert property (
    (ce_i && cnt_en && st_ff.ref_sel == 2'h0) |-> ref_inc)
    else $error("reference counter skipped a cycle at full rate");

  a_key_kept: assert property (
    (ce_i && st_ff.key_ovf && !ctl0_wr) |=> st_ff.key_ovf)
    else $error("key overflow flag cleared by hardware");

  a_ref_kept: assert property (
    (ce_i && st_ff.ref_ovf && !ctl0_wr) |=> st_ff.ref_ovf)
    else $error("reference overflow flag cleared by hardware");

  a_irq_clear: assert property (
    (ce_i && wr && wb_adr_i == OFS_IRQ && !wdat[0] && !slot_evt)
      |=> !irq_o)
    else $error("irq flag not cleared by software");

  a_ce_freeze: assert property (
    !ce_i |=> ($stable(st_ff) && $stable(key_cnt) && $stable(ref_cnt)))
    else $error("state moved while the clock enable was low");

  c_full_window: cover property (st_ff.run && slot_evt);
  c_key_wrap:    cover property (key_wrap);
  c_ref_wrap:    cover property (ref_wrap);
  c_abort:       cover property (st_ff.run ##1 $fell(st_ff.start));
  c_ce_hold:     cover property (!ce_i ##1 ce_i);

endmodule : tks_top

// ===== src/tks_pkg.sv
// Shared constants and types of the touch key scan counter block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package tks_pkg;

  // Word-aligned register byte offsets
  localparam logic [7:0] OFS_PRELOAD = 8'h00;
  localparam logic [7:0] OFS_CTL0    = 8'h04;
  localparam logic [7:0] OFS_CTL1    = 8'h08;
  localparam logic [7:0] OFS_REF_LO  = 8'h0C;
  localparam logic [7:0] OFS_REF_HI  = 8'h10;
  localparam logic [7:0] OFS_KEY_LO  = 8'h14;
  localparam logic [7:0] OFS_KEY_HI  = 8'h18;
  localparam logic [7:0] OFS_CAP_LO  = 8'h1C;
  localparam logic [7:0] OFS_CAP_HI  = 8'h20;
  localparam logic [7:0] OFS_MC0     = 8'h24;
  localparam logic [7:0] OFS_MC1     = 8'h28;
  localparam logic [7:0] OFS_IRQ     = 8'h2C;

  // touch_control_0 fields; B_KEY_SEL is a bit of the MC1 register
  localparam int B_SLOT_OVF = 6;
  localparam int B_START    = 5;
  localparam int B_KEY_OVF  = 4;
  localparam int B_REF_OVF  = 3;
  localparam int B_RSV      = 2;
  localparam int B_KEY_SEL  = 0;

  // Reset values
  localparam logic [1:0] FREQ_RST  = 2'h3;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [9:0] CAP_RST   = 10'h000;

  // Counter limits
  localparam logic [4:0] DIV_LAST  = 5'h1F;
  localparam logic [7:0] SLOT_LAST = 8'hFF;
  localparam logic [2:0] PRE_ZERO  = 3'h0;
  localparam logic [2:0] PRE_ONE   = 3'h1;
  localparam logic [4:0] DIV_ONE   = 5'h01;
  localparam logic [7:0] SLOT_ONE  = 8'h01;

  // Oscillator controls toward the analog front end
  typedef struct packed {
    logic       en;
    logic [1:0] freq;
    logic       key_sel;
    logic [9:0] cap;
  } tks_osc_s;

  // Select code to prescaler mask: f/1, f/2, f/4, f/8
  function automatic logic [2:0] tks_pre_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    tks_pre_mask = 3'h0;
      2'h1:    tks_pre_mask = 3'h1;
      2'h2:    tks_pre_mask = 3'h3;
      default: tks_pre_mask = 3'h7;
    endcase
  endfunction : tks_pre_mask

endpackage : tks_pkg

// ===== src/tks_cnt16.sv
// 16-bit event counter with clear and wrap-around overflow pulse.
// Assumes inc_i and clr_i are synchronous single-cycle qualifiers.
module tks_cnt16
  import tks_pkg::*;
(
  input  wire logic        clk_i, // System clock
  input  wire logic        rst_i, // Synchronous reset
  input  wire logic        ce_i,  // Clock enable
  input  wire logic        clr_i, // Hold at zero
  input  wire logic        inc_i, // Count one event
  output logic [15:0]      cnt_o, // Current count
  output logic             ovf_o  // Wrap this cycle
);

  typedef struct packed {
    logic [15:0] cnt;
  } tks_cnt_s;

  localparam logic [15:0] CNT_ONE = 16'h0001;

  tks_cnt_s cnt_ff;
  tks_cnt_s nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (clr_i) begin
      nxt_cnt.cnt = '0;
    end else if (inc_i) begin
      nxt_cnt.cnt = cnt_ff.cnt + CNT_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else if (ce_i) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign cnt_o = cnt_ff.cnt;
  assign ovf_o = inc_i && !clr_i && (&cnt_ff.cnt);

endmodule : tks_cnt16

// ===== tb/tks_top_tb.sv
// Self-checking bench for the touch key scan counter block.
// Assumes the tks_pkg register map; waits for each Wishbone ack.
module tks_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tks_pkg::*;

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); end end

  logic        clk_i, rst_i, ce_i, cyc, stb, we, slot_tick, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q, r0;
  logic [1:0]  key_tick;
  logic        ack;
  tks_osc_s    osc;
  int          err_count = 0;
  int          n_tests   = 0;

  tks_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .key_tick_i(key_tick), .slot_tick_i(slot_tick), .osc_o(osc),
    .irq_o(irq)
  );

  always #20 clk_i = ~clk_i;

  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // Every task starts on an edge and returns 1 ns after one
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d, output logic [31:0] o);
    int   i;
    logic got;
    got = 1'b0;
    o   = '0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    sel  <= 4'hF;
    for (i = 0; i < 20 && !got; i++) begin
      @(posedge clk_i);
      #1;
      got = (ack === 1'b1);
      o   = rdat;
    end
    if (!got) begin
      err_count++;
      give_verdict();
    end
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    #1;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] o;
    wb(1'b1, a, d, o);
  endtask : wr

  // Channel 1 pulses on the first nk ticks, channel 0 on all of them
  task automatic ticks(input int n, input int nk);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      slot_tick <= 1'b1;
      key_tick  <= {(i < nk), 1'b1};
      @(posedge clk_i);
      slot_tick <= 1'b0;
      key_tick  <= 2'h0;
    end
    #1;
  endtask : ticks

  //////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    wb(1'b0, OFS_CTL0, 8'h00, q);    `CHK(q, 32'h0)
    wb(1'b0, OFS_CTL1, 8'h00, q);    `CHK(q, 32'h3)
    wb(1'b0, OFS_PRELOAD, 8'h00, q); `CHK(q, 32'h0)
    wb(1'b0, 8'h30, 8'h00, q);       `CHK(q, 32'h0)
    `CHK(osc.freq, FREQ_RST)
    `CHK(osc.en, 1'b0)
    `CHK(irq, 1'b0)
    $display("test_reset done");
  endtask : test_reset

  task automatic test_bits();
    // Bit 7 stays zero: a one written there reads back as zero
    wr(OFS_CTL0, 8'h80);
    wb(1'b0, OFS_CTL0, 8'h00, q); `CHK(q, 32'h0)
    wr(OFS_CTL0, 8'h00);
    wr(OFS_CTL1, 8'h01);
    `CHK(osc.freq, 2'h1)
    wr(OFS_CTL1, 8'h03);
    $display("test_bits done");
  endtask : test_bits

  // Preload FE gives (256-254)*32 = 64 slot ticks
  task automatic test_scan();
    wr(OFS_PRELOAD, 8'hFE);
    wr(OFS_MC1, 8'h01);
    `CHK(osc.key_sel, 1'b1)
    wr(OFS_CTL0, 8'h23);
    `CHK(osc.en, 1'b1)
    ticks(63, 10);
    `CHK(osc.en, 1'b1)
    `CHK(irq, 1'b0)
    ticks(1, 0);
    @(posedge clk_i);
    #1;
    `CHK(osc.en, 1'b0)
    `CHK(irq, 1'b1)
    wb(1'b0, OFS_CTL0, 8'h00, q); `CHK(q[B_SLOT_OVF], 1'b1)
    wb(1'b0, OFS_KEY_LO, 8'h00, q); `CHK(q, 32'hA)
    wb(1'b0, OFS_REF_LO, 8'h00, r0);
    // 129 running cycles at f/8 from a cleared prescaler give 16; the check allows a margin
    `CHK(r0 > 32'hE && r0 < 32'h14, 1'b1)
    ticks(5, 5);
    wb(1'b0, OFS_KEY_LO, 8'h00, q); `CHK(q, 32'hA)
    wb(1'b0, OFS_REF_LO, 8'h00, q); `CHK(q, r0)
    $display("test_scan done");
  endtask : test_scan

  task automatic test_clear();
    wr(OFS_CTL0, 8'h00);
    wb(1'b0, OFS_KEY_LO, 8'h00, q); `CHK(q, 32'h0)
    wb(1'b0, OFS_REF_LO, 8'h00, q); `CHK(q, 32'h0)
    wr(OFS_IRQ, 8'h00);
    `CHK(irq, 1'b0)
    wr(OFS_CTL0, 8'h40);
    wb(1'b0, OFS_CTL0, 8'h00, q); `CHK(q, 32'h40)
    `CHK(irq, 1'b0)
    wr(OFS_CTL0, 8'h00);
    $display("test_clear done");
  endtask : test_clear

  // Preload 80 gives 4096 slot ticks, one every 17 cycles, so both
  // counters run at full rate for 69633 cycles and wrap once
  task automatic test_wrap();
    wr(OFS_PRELOAD, 8'h80);
    wr(OFS_MC1, 8'h00);
    @(posedge clk_i);
    key_tick <= 2'h1;
    wr(OFS_CTL0, 8'h20);
    for (int i = 0; i < 4096; i++) begin
      repeat (16) @(posedge clk_i);
      slot_tick <= 1'b1;
      @(posedge clk_i);
      slot_tick <= 1'b0;
    end
    @(posedge clk_i);
    key_tick <= 2'h0;
    #1;
    `CHK(osc.en, 1'b0)
    `CHK(irq, 1'b1)
    wb(1'b0, OFS_CTL0, 8'h00, q);   `CHK(q, 32'h78)
    wb(1'b0, OFS_KEY_LO, 8'h00, q); `CHK(q, 32'h01)
    wb(1'b0, OFS_KEY_HI, 8'h00, q); `CHK(q, 32'h10)
    wb(1'b0, OFS_REF_LO, 8'h00, q); `CHK(q, 32'h01)
    wb(1'b0, OFS_REF_HI, 8'h00, q); `CHK(q, 32'h10)
    wr(OFS_CTL0, 8'h00);
    wb(1'b0, OFS_CTL0, 8'h00, q);   `CHK(q, 32'h0)
    wr(OFS_IRQ, 8'h00);
    $display("test_wrap done");
  endtask : test_wrap

  // A request waits while the clock enable is low
  task automatic test_ce();
    @(posedge clk_i);
    ce_i <= 1'b0;
    fork
      wr(OFS_PRELOAD, 8'h5A);
      begin
        repeat (4) @(posedge clk_i);
        #1;
        `CHK(ack, 1'b0)
        @(posedge clk_i);
        ce_i <= 1'b1;
      end
    join
    wb(1'b0, OFS_PRELOAD, 8'h00, q); `CHK(q, 32'h5A)
    $display("test_ce done");
  endtask : test_ce

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i     = 1'b0;
    rst_i     = 1'b1;
    ce_i      = 1'b1;
    cyc       = 1'b0;
    stb       = 1'b0;
    we        = 1'b0;
    adr       = 8'h00;
    sel       = 4'h0;
    wdat      = 32'h0;
    slot_tick = 1'b0;
    key_tick  = 2'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_bits();
    test_scan();
    test_clear();
    test_wrap();
    test_ce();
    give_verdict();
  end

endmodule : tks_top_tb
